//--- rtl/preload_pkg.sv
// Constants and types shared by the register preload and power-up reset logic
package preload_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int REG_COUNT = 10;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS          = 100;
	localparam int POWER_UP_RESET_TIME_NS = 600;
	localparam int POWER_UP_RESET_MAX_NS  = 1000;
	// Least time, so rounded up to whole cycles, never below one
	localparam int POR_CYCLES_RAW = (POWER_UP_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_CYCLES     = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
	// Counter sized for the longest interval
	localparam int POR_CNT_W      = $clog2(POWER_UP_RESET_MAX_NS / CLK_PERIOD_NS + 1);

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic REG_RESET_VALUE = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_POR = 2'b00,
		MODE_ARM = 2'b01,
		MODE_RUN = 2'b10
	} mode_t;

	typedef struct packed
	{
		logic por_busy;
		logic armed;
		logic preload_active;
		logic load_strobe;
	} status_t;

	localparam status_t STATUS_RESET = '{por_busy: 1'b1, armed: 1'b0, preload_active: 1'b0, load_strobe: 1'b0};

endpackage : preload_pkg

//--- rtl/register_preload_powerup_reset.sv
// Output registers with power-up clear, polarity buffers and supervoltage preload
`timescale 1ns/1ns

module register_preload_powerup_reset #(
	parameter int N         = preload_pkg::REG_COUNT,
	parameter int POR_COUNT = preload_pkg::POR_CYCLES
)(
	// Clock and reset (reset stands for supply below threshold)
	input  wire logic                    mclk,
	input  wire logic                    srst,
	// Device clock pin and preload select
	input  wire logic                    dev_clk_pin,
	input  wire logic                    preload_hv,
	// Array results and per-cell configuration
	input  wire logic [N-1:0]            term_in,
	input  wire logic [N-1:0]            output_polarity_bit,
	input  wire logic [N-1:0]            drive_en,
	// Registered I/O pins
	input  wire logic [N-1:0]            pin_in,
	output logic      [N-1:0]            pin_out_q,
	output logic      [N-1:0]            pin_oe_q,
	// Register feedback and status
	output logic      [N-1:0]            feedback_q,
	output preload_pkg::status_t         status_q
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [N-1:0] apply_polarity(input logic [N-1:0] value, input logic [N-1:0] pol);
		// Polarity bit high passes the register straight, low inverts it
		apply_polarity = value ^ ~pol;
	endfunction : apply_polarity

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	preload_pkg::mode_t                  mode_q;
	preload_pkg::mode_t                  mode_d;
	logic [preload_pkg::POR_CNT_W-1:0]   por_cnt_q;
	logic                                clk_pin_q;
	logic                                clk_rise;
	logic                                por_done;
	logic                                preload_sel;
	logic [N-1:0]                        cell_q;
	logic [N-1:0]                        cell_d;
	logic                                load_now;

	// ------------------------------------------------------------
	// Clock pin edge detect
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			clk_pin_q <= 1'b0;
		end
		else
		begin
			clk_pin_q <= dev_clk_pin;
		end
	end

	assign clk_rise    = dev_clk_pin & ~clk_pin_q;
	assign preload_sel = preload_hv;
	assign por_done    = (por_cnt_q == preload_pkg::POR_CNT_W'(POR_COUNT - 1));

	// ------------------------------------------------------------
	// Power-up interval counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			por_cnt_q <= '0;
		end
		else if (mode_q == preload_pkg::MODE_POR && !por_done)
		begin
			por_cnt_q <= por_cnt_q + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		mode_d = mode_q;
		unique case (mode_q)
			preload_pkg::MODE_POR:
			begin
				// Clock is ignored for the whole interval
				if (por_done)
				begin
					mode_d = preload_pkg::MODE_ARM;
				end
			end
			preload_pkg::MODE_ARM:
			begin
				// A pin left high across reset would fake an edge; wait for low first
				if (!dev_clk_pin)
				begin
					mode_d = preload_pkg::MODE_RUN;
				end
			end
			preload_pkg::MODE_RUN:
			begin
				mode_d = preload_pkg::MODE_RUN;
			end
			default:
			begin
				mode_d = preload_pkg::MODE_POR;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mode_q <= preload_pkg::MODE_POR;
		end
		else
		begin
			mode_q <= mode_d;
		end
	end

	// ------------------------------------------------------------
	// Register cells
	// ------------------------------------------------------------
	assign load_now = (mode_q == preload_pkg::MODE_RUN) && clk_rise;

	always_comb
	begin
		cell_d = cell_q;
		if (mode_q == preload_pkg::MODE_POR)
		begin
			cell_d = {N{preload_pkg::REG_RESET_VALUE}};
		end
		else if (load_now && preload_sel)
		begin
			// Pin level taken as is; polarity plays no part here
			cell_d = pin_in;
		end
		else if (load_now)
		begin
			cell_d = term_in;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cell_q <= {N{preload_pkg::REG_RESET_VALUE}};
		end
		else
		begin
			cell_q <= cell_d;
		end
	end

	// ------------------------------------------------------------
	// Output buffers
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pin_out_q <= apply_polarity({N{preload_pkg::REG_RESET_VALUE}}, {N{1'b1}});
			pin_oe_q  <= '0;
		end
		else
		begin
			// Driven from the next value so pins track the cells without lag
			pin_out_q <= apply_polarity(cell_d, output_polarity_bit);
			// Tester owns the pins while preload is selected
			pin_oe_q  <= preload_sel ? '0 : drive_en;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			feedback_q <= {N{preload_pkg::REG_RESET_VALUE}};
		end
		else
		begin
			feedback_q <= cell_d;
		end
	end

	// ------------------------------------------------------------
	// Status
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			status_q <= preload_pkg::STATUS_RESET;
		end
		else
		begin
			status_q.por_busy       <= (mode_d == preload_pkg::MODE_POR);
			status_q.armed          <= (mode_d == preload_pkg::MODE_RUN);
			status_q.preload_active <= preload_sel;
			status_q.load_strobe    <= load_now;
		end
	end

endmodule : register_preload_powerup_reset

//--- sim/preload_checker_asserts.sv
// Checker for register preload and power-up reset outputs
`timescale 1ns/1ns
module preload_checker #(
	parameter int N = 10
)(
	input wire logic                  mclk,
	input wire logic                  srst,
	input wire logic                  dev_clk_pin,
	input wire logic                  preload_hv,
	input wire logic [N-1:0]          term_in,
	input wire logic [N-1:0]          output_polarity_bit,
	input wire logic [N-1:0]          drive_en,
	input wire logic [N-1:0]          pin_in,
	input wire logic [N-1:0]          pin_out_q,
	input wire logic [N-1:0]          pin_oe_q,
	input wire logic [N-1:0]          feedback_q,
	input wire preload_pkg::status_t  status_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	AST_RST_CLEAR: assert property (disable iff (1'b0) srst |=> feedback_q == '0)
		else $error("reset did not clear registers");
	AST_POR_HOLD: assert property (status_q.por_busy |-> feedback_q == '0 && !status_q.load_strobe)
		else $error("register changed during power-up");
	AST_POLARITY: assert property (!srst && !$past(srst) |->
		pin_out_q == (feedback_q ^ ~$past(output_polarity_bit)))
		else $error("pin level ignores polarity");
	AST_PLD_OE: assert property (preload_hv |=> pin_oe_q == '0 && status_q.preload_active)
		else $error("drivers on in preload");
	AST_RUN_OE: assert property (!srst && !preload_hv |=> pin_oe_q == $past(drive_en))
		else $error("output enable wrong");
	AST_RISE: assert property (status_q.load_strobe |-> $past(dev_clk_pin) && !$past(dev_clk_pin, 2))
		else $error("load without clock pin rise");
	AST_PLD_DATA: assert property (status_q.load_strobe && $past(preload_hv) |-> feedback_q == $past(pin_in))
		else $error("preload data wrong");
	AST_RUN_DATA: assert property (status_q.load_strobe && !$past(preload_hv) |-> feedback_q == $past(term_in))
		else $error("term data wrong");
	AST_HOLD: assert property (!srst && !$past(srst) && !status_q.load_strobe |-> $stable(feedback_q))
		else $error("register changed without load");
	AST_PULSE: assert property (status_q.load_strobe |=> !status_q.load_strobe)
		else $error("strobe longer than one cycle");
	AST_NO_EARLY: assert property (status_q.load_strobe |-> $past(status_q.armed))
		else $error("load accepted before run mode");
	COV_PLD: cover property (status_q.load_strobe && status_q.preload_active);
	COV_RUN: cover property (status_q.load_strobe && !status_q.preload_active);
	COV_POR: cover property ($fell(status_q.por_busy));
endmodule : preload_checker
bind register_preload_powerup_reset preload_checker #(.N(N)) u_chk (.mclk(mclk), .srst(srst),
	.dev_clk_pin(dev_clk_pin), .preload_hv(preload_hv), .term_in(term_in), .output_polarity_bit(output_polarity_bit),
	.drive_en(drive_en), .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .feedback_q(feedback_q),
	.status_q(status_q));

//--- sim/pin_fixture.sv
// Test fixture driving the device clock pin and the I/O pins
`timescale 1ns/1ns
module pin_fixture (
	input wire logic        mclk,
	input wire logic        fire,
	input wire logic        preload_hv,
	input wire logic [9:0]  pat,
	output logic            dev_clk_pin = 1'b0,
	output logic [9:0]      pin_in
);
	// Clock pin low unless asked, so setup and power-up hold are kept
	always_ff @(posedge mclk) dev_clk_pin <= fire;
	// Pins forced only in preload; otherwise inverted so stale data never matches
	assign pin_in = preload_hv ? pat : ~pat;
endmodule : pin_fixture

//--- sim/tb.sv
// Testbench for register preload and power-up reset
`timescale 1ns/1ns
module tb;
	logic                  mclk = 1'b0;
	logic                  srst = 1'b1;
	logic                  fire = 1'b0;
	logic                  preload_hv = 1'b0;
	logic [9:0]            term_in = 10'h155;
	logic [9:0]            pol = 10'h0f0;
	logic [9:0]            drive_en = 10'h3c3;
	logic [9:0]            pat = 10'h2c3;
	logic                  dev_clk_pin;
	logic [9:0]            pin_in, pin_out_q, pin_oe_q, feedback_q;
	preload_pkg::status_t  status_q;
	int                    failures = 0;
	int                    cmp_count = 0;
	always #50 mclk = ~mclk;
	register_preload_powerup_reset #(.POR_COUNT(4)) dut (.mclk(mclk), .srst(srst), .dev_clk_pin(dev_clk_pin),
		.preload_hv(preload_hv), .term_in(term_in), .output_polarity_bit(pol), .drive_en(drive_en),
		.pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .feedback_q(feedback_q), .status_q(status_q));
	pin_fixture u_fix (.mclk(mclk), .fire(fire), .preload_hv(preload_hv), .pat(pat), .dev_clk_pin(dev_clk_pin),
		.pin_in(pin_in));
	task chk(input logic [9:0] seen, input logic [9:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task pulse;
		@(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask : pulse
	// A rise during the power-up interval must be ignored
	task t_power_up;
		repeat (3) @(posedge mclk);
		#1;
		chk(feedback_q, 10'h000);
		@(posedge mclk);
		srst <= 1'b0;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		chk(feedback_q, 10'h000);
		chk(pin_out_q, ~pol);
		chk({9'h000, status_q.por_busy}, 10'h000);
		chk({9'h000, status_q.armed}, 10'h001);
	endtask : t_power_up
	// Mid-run reset with the clock pin stuck high: no load until it has been seen low
	task t_rearm;
		@(posedge mclk);
		srst <= 1'b1;
		fire <= 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		chk(feedback_q, 10'h000);
		chk({9'h000, status_q.armed}, 10'h000);
		@(posedge mclk);
		fire <= 1'b0;
		repeat (2) @(posedge mclk);
		pulse();
		chk(feedback_q, 10'h2aa);
		chk({9'h000, status_q.armed}, 10'h001);
	endtask : t_rearm
	task t_normal;
		pulse();
		chk(feedback_q, 10'h155);
		chk(pin_out_q, 10'h155 ^ ~pol);
	endtask : t_normal
	task t_preload;
		@(posedge mclk);
		preload_hv <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk(pin_oe_q, 10'h000);
		pulse();
		chk(feedback_q, 10'h2c3);
		chk(pin_out_q, 10'h2c3 ^ ~pol);
		@(posedge mclk);
		preload_hv <= 1'b0;
		term_in <= 10'h2aa;
		repeat (2) @(posedge mclk);
		#1;
		chk(pin_oe_q, drive_en);
		pulse();
		chk(feedback_q, 10'h2aa);
	endtask : t_preload
	initial
	begin
		repeat (500) @(posedge mclk);
		failures++;
		tally_and_finish();
	end
	initial
	begin
		t_power_up();
		t_normal();
		t_preload();
		t_rearm();
		tally_and_finish();
	end
endmodule : tb
